// File: src/slr_consts.svh
/*
 * Offsets, bit positions, reset values and sequence indices of the receive-link
 * interrupt block. Assumes it is included by bare name, once or more.
 */
`ifndef SLR_CONSTS_SVH
`define SLR_CONSTS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define SLR_ADDR_MASK_A 12'h4B8
`define SLR_ADDR_MASK_B 12'h4B9
`define SLR_ADDR_FLAGS_A 12'h4BA
`define SLR_ADDR_FLAGS_B 12'h4BB

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define SLR_BIT_DISPARITY 7
`define SLR_BIT_INVALID 6
`define SLR_BIT_STRAY 5
`define SLR_BIT_DESKEW 4
`define SLR_BIT_LANE_SYNC 3
`define SLR_BIT_CHECKSUM 2
`define SLR_BIT_FRAME_SYNC 1
`define SLR_BIT_CGS 0
`define SLR_BIT_MISMATCH 0
`define SLR_RESET_BYTE 8'h00

// ----------------------------------------------------------------
// alignment sequence layout
// ----------------------------------------------------------------
`define SLR_ILAS_LAST_IDX 4'hD
`define SLR_ILAS_CKS_IDX 4'hD
`define SLR_CHECK_LANE 3'h0

`endif

// File: src/slr_ilas_check.sv
/*
 * Alignment-sequence checker for one lane: running checksum and
 * comparison against programmed parameters.
 * Assumes octets arrive in index order 0..13, one per valid cycle.
 */
`timescale 1ns/100ps
`default_nettype none

module slr_ilas_check
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // received octets of the checked lane
    input wire logic octet_valid,
    input wire logic [3:0] octet_index,
    input wire logic [7:0] octet_data,
    // programmed parameters
    input wire slr_pkg::slr_params_t cfg_params,
    // results, one-cycle pulses after the last octet
    output logic checksum_bad,
    output logic mismatch
);
    import slr_pkg::*;
    `include "slr_consts.svh"

    logic [7:0] sum_reg;
    logic [7:0] sum_next;
    logic diff_reg;
    logic diff_next;
    logic cks_bad_reg;
    logic mis_reg;
    wire first_w = octet_valid && (octet_index == 4'h0);
    wire last_w = octet_valid && (octet_index == `SLR_ILAS_LAST_IDX);
    wire is_cks_w = (octet_index == `SLR_ILAS_CKS_IDX);
    wire [7:0] base_sum_w = first_w ? 8'h00 : sum_reg;
    wire base_diff_w = first_w ? 1'b0 : diff_reg;
    wire octet_diff_w = (octet_data != cfg_params[octet_index]);

    assign sum_next = (octet_valid && !is_cks_w) ? (base_sum_w + octet_data) : sum_reg;
    assign diff_next = octet_valid ? (base_diff_w | octet_diff_w) : diff_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            sum_reg <= 8'h00;
            diff_reg <= 1'b0;
            cks_bad_reg <= 1'b0;
            mis_reg <= 1'b0;
        end else begin
            sum_reg <= sum_next;
            diff_reg <= diff_next;
            cks_bad_reg <= last_w && (octet_data != sum_reg);
            mis_reg <= last_w && diff_next;
        end
    end

    assign checksum_bad = cks_bad_reg;
    assign mismatch = mis_reg;

endmodule

`default_nettype wire

// File: src/slr_irq_logic.sv
/*
 * Receive-link interrupt enables and flags with their register access.
 * Assumes a configuration-port slave outside delivers byte reads and
 * writes synchronous to clk, and that lane status, error counts and
 * alignment octets come from the deserializer on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

module slr_irq_logic
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register access from the configuration port
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // link status from the deserializer
    input wire slr_pkg::slr_lane_stat_t lane_stat,
    input wire slr_pkg::slr_lane_cnt_t lane_cnt,
    input wire logic [7:0] error_count_threshold,
    input wire slr_pkg::slr_ilas_octet_t ilas_octet,
    // programmed link parameters
    input wire slr_pkg::slr_params_t cfg_params,
    // per-lane error status and interrupt request
    output logic [7:0] disparity_status,
    output logic [7:0] invalid_status,
    output logic [7:0] stray_status,
    output logic irq
);
    import slr_pkg::*;
    `include "slr_consts.svh"

    // ----------------------------------------------------------------
    // per-lane error status
    // ----------------------------------------------------------------
    logic [7:0] disp_w;
    logic [7:0] inv_w;
    logic [7:0] stray_w;

    genvar ln;
    generate
        for (ln = 0; ln < 8; ln = ln + 1) begin : g_lane
            assign disp_w[ln] = (lane_cnt.disparity[ln] >= error_count_threshold);
            assign inv_w[ln] = (lane_cnt.invalid[ln] >= error_count_threshold);
            assign stray_w[ln] = (lane_cnt.stray[ln] >= error_count_threshold);
        end
    endgenerate

    // ----------------------------------------------------------------
    // event detection
    // ----------------------------------------------------------------
    logic [7:0] disp_q;
    logic [7:0] inv_q;
    logic [7:0] stray_q;
    slr_lane_stat_t stat_q;
    logic cks_bad_w;
    logic mismatch_w;

    // only lane 0 reaches the checker
    wire lane0_valid_w = ilas_octet.valid && (ilas_octet.lane == `SLR_CHECK_LANE);

    slr_ilas_check i_slr_ilas_check (
        .clk(clk),
        .resetn(resetn),
        .octet_valid(lane0_valid_w),
        .octet_index(ilas_octet.index),
        .octet_data(ilas_octet.data),
        .cfg_params(cfg_params),
        .checksum_bad(cks_bad_w),
        .mismatch(mismatch_w)
    );

    // error counters fire on crossing the threshold, sync bits on loss
    wire evt_disp_w = |(disp_w & ~disp_q);
    wire evt_inv_w = |(inv_w & ~inv_q);
    wire evt_stray_w = |(stray_w & ~stray_q);
    wire evt_deskew_w = |(stat_q.deskew & ~lane_stat.deskew);
    wire evt_lsync_w = |(stat_q.lane_sync & ~lane_stat.lane_sync);
    wire evt_fsync_w = |(stat_q.frame_sync & ~lane_stat.frame_sync);
    wire evt_cgs_w = |(stat_q.cgs & ~lane_stat.cgs);

    logic [7:0] evt_a_w;
    assign evt_a_w[`SLR_BIT_DISPARITY] = evt_disp_w;
    assign evt_a_w[`SLR_BIT_INVALID] = evt_inv_w;
    assign evt_a_w[`SLR_BIT_STRAY] = evt_stray_w;
    assign evt_a_w[`SLR_BIT_DESKEW] = evt_deskew_w;
    assign evt_a_w[`SLR_BIT_LANE_SYNC] = evt_lsync_w;
    assign evt_a_w[`SLR_BIT_CHECKSUM] = cks_bad_w;
    assign evt_a_w[`SLR_BIT_FRAME_SYNC] = evt_fsync_w;
    assign evt_a_w[`SLR_BIT_CGS] = evt_cgs_w;

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    logic [7:0] mask_a_reg;
    logic mask_b_reg;
    logic [7:0] flags_a_reg;
    logic [7:0] flags_a_next;
    logic flags_b_reg;
    logic flags_b_next;
    logic [7:0] rdata_reg;

    wire hit_mask_a_w = (reg_addr == `SLR_ADDR_MASK_A);
    wire hit_mask_b_w = (reg_addr == `SLR_ADDR_MASK_B);
    wire hit_flags_a_w = (reg_addr == `SLR_ADDR_FLAGS_A);
    wire hit_flags_b_w = (reg_addr == `SLR_ADDR_FLAGS_B);
    wire [7:0] clr_a_w = (reg_wr && hit_flags_a_w) ? reg_wdata : 8'h00;
    wire clr_b_w = reg_wr && hit_flags_b_w && reg_wdata[`SLR_BIT_MISMATCH];

    // write one clears, a new event wins
    assign flags_a_next = (flags_a_reg & ~clr_a_w) | evt_a_w;
    assign flags_b_next = (flags_b_reg & ~clr_b_w) | mismatch_w;

    wire [7:0] rd_mux_w = hit_mask_a_w ? mask_a_reg :
                          hit_mask_b_w ? {7'h00, mask_b_reg} :
                          hit_flags_a_w ? flags_a_reg :
                          hit_flags_b_w ? {7'h00, flags_b_reg} :
                          8'h00;

    // error status history: a flag marks the crossing, not every cycle above
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            disp_q <= 8'h00;
            inv_q <= 8'h00;
            stray_q <= 8'h00;
        end else begin
            disp_q <= disp_w;
            inv_q <= inv_w;
            stray_q <= stray_w;
        end
    end

    // resets to all-lost so a link already up at release raises no false loss
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            stat_q <= '0;
        end else begin
            stat_q <= lane_stat;
        end
    end

    wire wr_mask_a_w = reg_wr && hit_mask_a_w;
    wire wr_mask_b_w = reg_wr && hit_mask_b_w;

    // mask A: plain read/write byte
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask_a_reg <= `SLR_RESET_BYTE;
        end else if (wr_mask_a_w) begin
            mask_a_reg <= reg_wdata;
        end
    end

    // mask B: only bit 0 is stored, so upper bits can never read back set
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            mask_b_reg <= 1'b0;
        end else if (wr_mask_b_w) begin
            mask_b_reg <= reg_wdata[`SLR_BIT_MISMATCH];
        end
    end

    // flags A: events keep landing even while masked
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_a_reg <= `SLR_RESET_BYTE;
        end else begin
            flags_a_reg <= flags_a_next;
        end
    end

    // flag B: single stored bit
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_b_reg <= 1'b0;
        end else begin
            flags_b_reg <= flags_b_next;
        end
    end

    // read data holds between reads so the port may fetch it late
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_reg <= `SLR_RESET_BYTE;
        end else if (reg_rd) begin
            rdata_reg <= rd_mux_w;
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // masked flags gate the request
    assign irq = (|(flags_a_reg & mask_a_reg)) | (flags_b_reg & mask_b_reg);
    assign reg_rdata = rdata_reg;
    assign disparity_status = disp_q;
    assign invalid_status = inv_q;
    assign stray_status = stray_q;

endmodule

`default_nettype wire

// File: src/slr_pkg.sv
/*
 * Types of the receive-link interrupt block.
 * Assumes slr_consts.svh is compiled alongside.
 */
package slr_pkg;

    // one octet of the alignment sequence, tagged with lane and position
    typedef struct packed {
        logic valid;
        logic [2:0] lane;
        logic [3:0] index;
        logic [7:0] data;
    } slr_ilas_octet_t;

    // per-lane sync and deskew status, one bit per lane
    typedef struct packed {
        logic [7:0] cgs;
        logic [7:0] frame_sync;
        logic [7:0] lane_sync;
        logic [7:0] deskew;
    } slr_lane_stat_t;

    // per-lane error counts, one byte per lane
    typedef struct packed {
        logic [7:0][7:0] disparity;
        logic [7:0][7:0] invalid;
        logic [7:0][7:0] stray;
    } slr_lane_cnt_t;

    // programmed link parameters, octet 0 first
    typedef logic [13:0][7:0] slr_params_t;

endpackage

// File: test/slr_ilas_tx_model.sv
/* transmitter sending one alignment sequence of 14 octets per start.
   assumes start is a one-cycle pulse given while busy is low */
`timescale 1ns/100ps
`default_nettype none
module slr_ilas_tx_model
(
    // control
    input wire logic clk,
    input wire logic start,
    input wire logic [2:0] lane,
    input wire logic bad_cks,
    input wire slr_pkg::slr_params_t params,
    // link side
    output var slr_pkg::slr_ilas_octet_t octet,
    output logic busy
);
    import slr_pkg::*;
    logic [3:0] idx = 4'h0;
    logic [7:0] sum = 8'h00;
    initial octet = '0;
    initial busy = 1'b0;
    // ----------------------------------------------------------------
    // octet sender
    // ----------------------------------------------------------------
    always @(posedge clk) begin
        if (start && !busy) begin
            busy <= 1'b1;
            idx <= 4'h0;
            sum <= 8'h00;
        end
        if (busy) begin
            // last octet carries the running sum, flipped in its lsb on request
            octet <= '{1'b1, lane, idx, (idx == 4'hD) ? sum ^ {7'h00, bad_cks} : params[idx]};
            sum <= sum + params[idx];
            idx <= idx + 4'h1;
            busy <= idx != 4'hD;
        end else begin
            // idle data toggles so stale octets never look valid by accident
            octet <= '{1'b0, 3'h0, 4'h0, ~octet.data};
        end
    end
endmodule
`default_nettype wire

// File: test/slr_irq_checker.sv
/* assertions on the ports of the receive-link interrupt block.
   assumes it is bound from the bench top onto slr_irq_logic */
`timescale 1ns/100ps
`default_nettype none
module slr_irq_checker
(
    // clock and reset
    input wire logic clk,
    input wire logic resetn,
    // register port
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // status and request
    input wire slr_pkg::slr_lane_cnt_t lane_cnt,
    input wire logic [7:0] error_count_threshold,
    input wire logic [7:0] disparity_status,
    input wire logic [7:0] invalid_status,
    input wire logic [7:0] stray_status,
    input wire logic irq
);
    import slr_pkg::*;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    a_disp_at_thr: assert property (
        lane_cnt.disparity[2] >= error_count_threshold |=> disparity_status[2]) else $error("disparity status low");
    a_inval_below_thr: assert property (
        lane_cnt.invalid[2] < error_count_threshold |=> !invalid_status[2]) else $error("invalid status high");
    a_stray_at_thr: assert property (
        lane_cnt.stray[2] >= error_count_threshold |=> stray_status[2]) else $error("stray status low");
    a_flags_b_reserved: assert property (
        reg_rd && reg_addr == 12'h4BB |=> reg_rdata[7:1] == 7'h00) else $error("flag reserved bits set");
    a_mask_b_reserved: assert property (
        reg_rd && reg_addr == 12'h4B9 |=> reg_rdata[7:1] == 7'h00) else $error("mask reserved bits set");
    a_rdata_holds: assert property (
        !reg_rd |=> $stable(reg_rdata)) else $error("read data moved");
    a_irq_drop_write: assert property (
        $fell(irq) |-> $past(reg_wr)) else $error("irq fell without write");
    a_irq_reset_low: assert property (
        $rose(resetn) |-> !irq) else $error("irq high after reset");
endmodule
`default_nettype wire

// File: test/tb_slr_irq_logic.sv
/* bench of the receive-link interrupt block: registers, link events, alignment checks.
   assumes the checker and the transmitter model are compiled first */
`timescale 1ns/100ps
`default_nettype none
module tb_slr_irq_logic;
    import slr_pkg::*;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata, dsp, inv, stry, thr = 8'h10;
    slr_lane_stat_t lane_stat = '1;
    slr_lane_cnt_t lane_cnt = '0;
    slr_ilas_octet_t octet;
    slr_params_t cfg = '0;
    slr_params_t tp;
    logic irq, busy, start = 1'b0, bad = 1'b0;
    logic [2:0] lane = 3'h0;
    int err_count = 0;
    int checks_done = 0;
    always #12.5 clk = ~clk;
    slr_irq_logic i_slr_irq_logic (.clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lane_stat(lane_stat), .lane_cnt(lane_cnt),
        .error_count_threshold(thr), .ilas_octet(octet), .cfg_params(cfg), .disparity_status(dsp),
        .invalid_status(inv), .stray_status(stry), .irq(irq));
    slr_ilas_tx_model i_slr_ilas_tx_model (.clk(clk), .start(start), .lane(lane), .bad_cks(bad), .params(tp),
        .octet(octet), .busy(busy));
    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string name);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 check(name, reg_rdata, exp);
    endtask
    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        for (int a = 12'h4B8; a <= 12'h4BB; a++) rd(12'(a), 8'h00, "reset value");
        rd(12'h000, 8'h00, "unmapped");
    endtask
    task automatic t_flags();
        @(posedge clk);
        lane_cnt <= {3{64'h0000_0000_000F_0000}};
        repeat (3) @(posedge clk);
        #1 check("below threshold", dsp | inv | stry, 8'h00);
        @(posedge clk);
        lane_cnt <= {3{64'h0000_0000_0010_0000}};
        lane_stat <= {4{8'hFE}};
        repeat (3) @(posedge clk);
        #1 check("at threshold", dsp & inv & stry, 8'h04);
        rd(12'h4BA, 8'hFB, "flags a");
        check("irq masked", {7'h00, irq}, 8'h00);
        wr(12'h4B8, 8'h80);
        #1 check("irq on", {7'h00, irq}, 8'h01);
        wr(12'h4BA, 8'h7F);
        rd(12'h4BA, 8'h80, "flags cleared");
        wr(12'h4BA, 8'h80);
        #1 check("irq off", {7'h00, irq}, 8'h00);
        wr(12'h4B9, 8'hFF);
        rd(12'h4B9, 8'h01, "mask b");
        wr(12'h4BB, 8'hFF);
        rd(12'h4BB, 8'h00, "flags b");
    endtask
    task automatic t_ilas(input logic b, input logic [3:0] di, input logic [7:0] dv, input logic [2:0] ln,
        input logic [7:0] ea, input logic [7:0] eb);
        int n;
        logic [7:0] s;
        slr_params_t c;
        s = 8'h00;
        for (n = 0; n < 13; n++) s += tp[n];
        c = tp;
        c[13] = s ^ {7'h00, b};
        c[di] = c[di] ^ dv;
        @(posedge clk);
        cfg <= c;
        bad <= b;
        lane <= ln;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        #1;
        for (n = 0; n < 40 && busy !== 1'b0; n++) @(posedge clk);
        if (n == 40) begin
            check("transmitter done", 8'h00, 8'h01);
            results();
        end else begin
            repeat (2) @(posedge clk);
            rd(12'h4BA, ea, "checksum flag");
            rd(12'h4BB, eb, "mismatch flag");
            check("irq mismatch", {7'h00, irq}, eb);
            wr(12'h4BA, 8'hFF);
            wr(12'h4BB, 8'h01);
        end
    endtask
    // a reset in mid-run drops the request and clears flags and masks
    task automatic t_midreset();
        wr(12'h4B8, 8'hFF);
        @(posedge clk);
        lane_cnt <= '0;
        lane_stat <= {4{8'hFC}};
        repeat (2) @(posedge clk);
        #1 check("irq before reset", {7'h00, irq}, 8'h01);
        @(posedge clk);
        resetn <= 1'b0;
        #1 check("irq in reset", {7'h00, irq}, 8'h00);
        check("rdata in reset", reg_rdata, 8'h00);
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        rd(12'h4BA, 8'h00, "flags after reset");
        rd(12'h4B8, 8'h00, "mask after reset");
    endtask
    initial begin
        for (int i = 0; i < 14; i++) tp[i] = 8'h10 + 8'(i);
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        t_reset();
        t_flags();
        t_ilas(1'b0, 4'h0, 8'h00, 3'h0, 8'h00, 8'h00);
        t_ilas(1'b1, 4'h0, 8'h00, 3'h0, 8'h04, 8'h00);
        t_ilas(1'b0, 4'hD, 8'h01, 3'h0, 8'h00, 8'h01);
        t_ilas(1'b0, 4'h5, 8'h80, 3'h0, 8'h00, 8'h01);
        t_ilas(1'b1, 4'h5, 8'h80, 3'h3, 8'h00, 8'h00);
        t_midreset();
        results();
    end
endmodule
bind slr_irq_logic slr_irq_checker i_slr_irq_checker (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lane_cnt(lane_cnt),
    .error_count_threshold(error_count_threshold), .disparity_status(disparity_status),
    .invalid_status(invalid_status), .stray_status(stray_status), .irq(irq));
`default_nettype wire
